// *** core/eeprom_pkg.sv ***
// Shared constants and types for the two-wire EEPROM target
package eeprom_pkg;
  localparam int          CLK_MHZ       = 125;
  localparam int          T_WR_MS       = 10;
  localparam int          WR_CYCLES_DEF = T_WR_MS * 1000 * CLK_MHZ;
  localparam int          MEM_BYTES_DEF = 8192;
  localparam int          ADDR_MAX_W    = 13;
  localparam int          PAGE_BITS     = 5;
  localparam logic [3:0]  DEV_TYPE      = 4'hA;
  localparam logic [3:0]  BIT_LAST      = 4'h8;
  localparam logic [3:0]  ACK_BIT       = 4'h9;
  localparam logic [1:0]  LINE_IDLE     = 2'h3;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DEV  = 6'h02,
    S_AHI  = 6'h04,
    S_ALO  = 6'h08,
    S_WR   = 6'h10,
    S_RD   = 6'h20
  } state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

  typedef struct packed {
    logic                  we;
    logic [ADDR_MAX_W-1:0] addr;
    logic [7:0]            data;
  } mem_wr_s;
endpackage

// *** core/eeprom_mem.sv ***
// Byte array of the EEPROM with registered read data
`timescale 1ns/1ps
module eeprom_mem #(
  parameter int DEPTH  = 8192,
  parameter int ADDR_W = 13
) (
  input  wire logic                 ref_clk,
  input  wire eeprom_pkg::mem_wr_s  wr,
  input  wire logic [ADDR_W-1:0]    rd_addr,
  output logic [7:0]                rd_data
);
  import eeprom_pkg::*;

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rd_data_reg;

  // No reset: array content is the stored data, unknown until written
  always_ff @(posedge ref_clk) begin
    if (wr.we) begin
      mem_reg[wr.addr[ADDR_W-1:0]] <= wr.data;
    end
    rd_data_reg <= mem_reg[rd_addr];
  end

  assign rd_data = rd_data_reg;
endmodule

// *** core/eeprom_twowire_target.sv ***
// Two-wire serial EEPROM target: protocol engine, address counter, write timer
`timescale 1ns/1ps
module eeprom_twowire_target #(
  parameter int MEM_BYTES = eeprom_pkg::MEM_BYTES_DEF,
  parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES_DEF
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic chip_select_pin_high,
  input  wire logic chip_select_pin_mid,
  input  wire logic chip_select_pin_low,
  input  wire logic write_protect,
  output logic      write_busy
);
  import eeprom_pkg::*;

  localparam int ADDR_W = $clog2(MEM_BYTES);
  localparam int CNT_W  = $clog2(WR_CYCLES + 1);

  generate
    if ((MEM_BYTES != 4096 && MEM_BYTES != 8192) || WR_CYCLES < 1) begin : g_bad
      $error("eeprom_twowire_target: unsupported MEM_BYTES or WR_CYCLES");
    end
  endgenerate

  function automatic logic in_top_quarter(input logic [ADDR_W-1:0] a);
    return &a[ADDR_W-1:ADDR_W-2];
  endfunction

  // Pin synchronisers; floating straps resolve low at the pad
  line_s      line_meta_reg, line_sync_reg, line_prev_reg;
  logic [3:0] pin_meta_reg, pin_sync_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_meta_reg <= line_s'(LINE_IDLE);
      line_sync_reg <= line_s'(LINE_IDLE);
      line_prev_reg <= line_s'(LINE_IDLE);
      pin_meta_reg  <= 4'h0;
      pin_sync_reg  <= 4'h0;
    end else begin
      line_meta_reg <= '{scl: scl_i, sda: sda_i};
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
      pin_meta_reg  <= {chip_select_pin_high, chip_select_pin_mid,
                        chip_select_pin_low, write_protect};
      pin_sync_reg  <= pin_meta_reg;
    end
  end

  logic       scl_rise, scl_fall, start_det, stop_det, wp_sync, dev_match;
  logic [2:0] sel_sync;

  assign scl_rise  = line_sync_reg.scl & ~line_prev_reg.scl;
  assign scl_fall  = ~line_sync_reg.scl & line_prev_reg.scl;
  assign start_det = line_sync_reg.scl & line_prev_reg.scl
                     & line_prev_reg.sda & ~line_sync_reg.sda;
  assign stop_det  = line_sync_reg.scl & line_prev_reg.scl
                     & ~line_prev_reg.sda & line_sync_reg.sda;
  assign sel_sync  = pin_sync_reg[3:1];
  assign wp_sync   = pin_sync_reg[0];

  // Protocol state
  state_e             state_reg, state_next;
  logic [3:0]         bit_cnt_reg, bit_cnt_next;
  logic [7:0]         shift_reg, shift_next;
  logic [7:0]         tx_reg, tx_next;
  logic [7:0]         addr_hi_reg, addr_hi_next;
  logic [ADDR_W-1:0]  addr_reg, addr_next;
  logic               rw_reg, rw_next;
  logic               oe_reg, oe_next;
  logic               mack_reg, mack_next;
  logic               pend_reg, pend_next;
  logic [CNT_W-1:0]   busy_cnt_reg, busy_cnt_next;
  logic [15:0]        addr_wide;
  logic [7:0]         rd_data;
  mem_wr_s            mem_wr;

  assign dev_match = (shift_reg[7:4] == DEV_TYPE)
                     && (shift_reg[3:1] == sel_sync);
  assign addr_wide = {addr_hi_reg, shift_reg};

  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    tx_next       = tx_reg;
    addr_hi_next  = addr_hi_reg;
    addr_next     = addr_reg;
    rw_next       = rw_reg;
    oe_next       = oe_reg;
    mack_next     = mack_reg;
    pend_next     = pend_reg;
    busy_cnt_next = busy_cnt_reg;
    mem_wr        = '0;
    if (busy_cnt_reg != '0) begin
      busy_cnt_next = busy_cnt_reg - 1'b1;
    end
    if (stop_det) begin
      state_next = S_IDLE;
      oe_next    = 1'b0;
      if (pend_reg) begin
        busy_cnt_next = CNT_W'(WR_CYCLES);
        pend_next     = 1'b0;
      end
    end else if (start_det) begin
      oe_next      = 1'b0;
      bit_cnt_next = 4'h0;
      // A start while programming leaves the device deaf to the whole command
      state_next   = (busy_cnt_reg != '0) ? S_IDLE : S_DEV;
    end else if (state_reg != S_IDLE) begin
      if (scl_rise) begin
        bit_cnt_next = bit_cnt_reg + 4'h1;
        if (bit_cnt_reg < BIT_LAST) begin
          shift_next = {shift_reg[6:0], line_sync_reg.sda};
        end else begin
          mack_next = ~line_sync_reg.sda;
          if (state_reg == S_RD) begin
            // Full-width add wraps the last byte back to zero
            addr_next = addr_reg + 1'b1;
          end
        end
      end else if (scl_fall) begin
        if (bit_cnt_reg == BIT_LAST) begin
          oe_next = 1'b1;
          case (state_reg)
            S_DEV: begin
              if (!dev_match) begin
                oe_next    = 1'b0;
                state_next = S_IDLE;
              end else begin
                rw_next = shift_reg[0];
              end
            end
            S_AHI: addr_hi_next = shift_reg;
            S_ALO: addr_next = addr_wide[ADDR_W-1:0];
            S_WR: begin
              // Blocked bytes are still acknowledged; the store and the programming cycle are dropped
              if (!(wp_sync && in_top_quarter(addr_reg))) begin
                mem_wr.we   = 1'b1;
                mem_wr.addr = ADDR_MAX_W'(addr_reg);
                mem_wr.data = shift_reg;
                pend_next   = 1'b1;
              end
              addr_next = {addr_reg[ADDR_W-1:PAGE_BITS],
                           addr_reg[PAGE_BITS-1:0] + 1'b1};
            end
            S_RD: oe_next = 1'b0;
            default: oe_next = 1'b0;
          endcase
        end else if (bit_cnt_reg == ACK_BIT) begin
          bit_cnt_next = 4'h0;
          oe_next      = 1'b0;
          case (state_reg)
            S_DEV: begin
              if (rw_reg) begin
                state_next = S_RD;
                tx_next    = rd_data;
                oe_next    = ~rd_data[7];
              end else begin
                state_next = S_AHI;
              end
            end
            S_AHI: state_next = S_ALO;
            S_ALO: state_next = S_WR;
            S_RD: begin
              if (mack_reg) begin
                tx_next = rd_data;
                oe_next = ~rd_data[7];
              end else begin
                state_next = S_IDLE;
              end
            end
            default: state_next = state_reg;
          endcase
        end else if (state_reg == S_RD) begin
          oe_next = ~tx_reg[3'd7 - bit_cnt_reg[2:0]];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      addr_hi_reg  <= 8'h00;
      addr_reg     <= '0;
      rw_reg       <= 1'b0;
      oe_reg       <= 1'b0;
      mack_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
      tx_reg       <= tx_next;
      addr_hi_reg  <= addr_hi_next;
      addr_reg     <= addr_next;
      rw_reg       <= rw_next;
      oe_reg       <= oe_next;
      mack_reg     <= mack_next;
      pend_reg     <= pend_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  eeprom_mem #(
    .DEPTH  (MEM_BYTES),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .wr      (mem_wr),
    .rd_addr (addr_reg),
    .rd_data (rd_data)
  );

  // Open drain: only ever pulls low
  assign sda_o      = 1'b0;
  assign sda_oe     = oe_reg;
  assign write_busy = (busy_cnt_reg != '0);

  // Checks
  logic byte_end, ack_end, quiet;
  assign quiet    = ~start_det & ~stop_det;
  assign byte_end = quiet & scl_fall & (bit_cnt_reg == BIT_LAST) & (state_reg != S_IDLE);
  assign ack_end  = quiet & scl_fall & (bit_cnt_reg == ACK_BIT) & (state_reg != S_IDLE);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_start_to_dev: assert property (start_det && !stop_det && !write_busy
    |=> state_reg == S_DEV && bit_cnt_reg == 4'h0)
    else $error("start not taken");
  a_stop_to_idle: assert property (stop_det
    |=> state_reg == S_IDLE && !sda_oe)
    else $error("stop did not end transfer");
  a_dev_ack: assert property (byte_end && state_reg == S_DEV && dev_match
    |=> sda_oe && rw_reg == $past(shift_reg[0]))
    else $error("matching device word not acknowledged");
  a_dev_nack: assert property (byte_end && state_reg == S_DEV && !dev_match
    |=> !sda_oe && state_reg == S_IDLE)
    else $error("mismatching device word acknowledged");
  a_rx_ack: assert property (byte_end && state_reg inside {S_AHI, S_ALO, S_WR}
    |=> sda_oe)
    else $error("received word not acknowledged");
  a_busy_quiet: assert property (write_busy
    |-> !sda_oe && state_reg == S_IDLE)
    else $error("device answered while programming");
  a_wp_block: assert property (mem_wr.we
    |-> !(wp_sync && in_top_quarter(addr_reg)))
    else $error("protected quarter written");
  a_page_keep: assert property (byte_end && state_reg == S_WR
    |=> addr_reg[ADDR_W-1:PAGE_BITS] == $past(addr_reg[ADDR_W-1:PAGE_BITS])
        && addr_reg[PAGE_BITS-1:0] == PAGE_BITS'($past(addr_reg[PAGE_BITS-1:0]) + 1'b1))
    else $error("write address left its page");
  a_read_wrap: assert property (quiet && scl_rise && bit_cnt_reg == BIT_LAST
    && state_reg == S_RD && &addr_reg |=> addr_reg == '0)
    else $error("read address did not wrap to zero");
  a_busy_load: assert property (stop_det && pend_reg
    |=> busy_cnt_reg == CNT_W'(WR_CYCLES) ##1 write_busy)
    else $error("programming cycle not started");
  a_read_first: assert property (ack_end && state_reg == S_DEV && rw_reg
    |=> state_reg == S_RD && tx_reg == $past(rd_data) && sda_oe == ~tx_reg[7])
    else $error("read byte not presented");

  c_page_byte: cover property (byte_end && state_reg == S_WR);
  c_seq_read: cover property (ack_end && state_reg == S_RD && mack_reg);
  c_prog_start: cover property (stop_det && pend_reg);
  c_dev_miss: cover property (byte_end && state_reg == S_DEV && !dev_match);
endmodule

// *** verification/twowire_master.sv ***
// Behavioural two-wire bus master driving the link clock and pulling the data wire
`timescale 1ns/1ps
module twowire_master (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Quarter of the 125 ns link period; data bits move only mid-low
  localparam realtime Q = 31.25;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Also serves as repeated start when entered with the clock low
  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
  endtask

  // Clock is left high afterwards: it stands still between frames
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask

  task automatic bit_io(input logic b, output logic r);
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // A master acknowledge asks for the next byte; no acknowledge ends the read
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~mack, r);
  endtask
endmodule

// *** verification/test_serial_eeprom_twowire_target.sv ***
// Self-checking bench of the two-wire EEPROM target against a byte-array model
`timescale 1ns/1ps
module test_serial_eeprom_twowire_target;
  import eeprom_pkg::*;
  logic       ref_clk;
  logic       rst;
  logic       scl;
  logic       m_pull;
  logic       sda_o;
  logic       sda_oe;
  logic       write_busy;
  logic       wp;
  logic [2:0] cs;
  // Pull-up wire: the device pulls low only while enabled and driving a zero
  wire        sda = ~(m_pull | (sda_oe & ~sda_o));
  int         fails;
  int         samples_checked;
  int         cnt;
  logic [7:0] mem [int];
  logic       ack;
  logic [7:0] b;

  eeprom_twowire_target #(.MEM_BYTES(8192), .WR_CYCLES(200)) dut (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .scl_i                (scl),
    .sda_i                (sda),
    .sda_o                (sda_o),
    .sda_oe               (sda_oe),
    .chip_select_pin_high (cs[2]),
    .chip_select_pin_mid  (cs[1]),
    .chip_select_pin_low  (cs[0]),
    .write_protect        (wp),
    .write_busy           (write_busy)
  );

  twowire_master m (
    .scl      (scl),
    .sda_pull (m_pull),
    .sda      (sda)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_ack(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t flag exp %b got %b", $time, exp, got);
    end
  endtask

  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t byte exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic dev(input logic rw, input logic exp);
    m.start();
    m.wbyte({DEV_TYPE, cs, rw}, ack);
    chk_ack(exp, ack);
  endtask

  // Bits above the 13-bit array width are dropped by the model too
  task automatic addr(input logic [15:0] a);
    m.wbyte(a[15:8], ack);
    chk_ack(1'b1, ack);
    m.wbyte(a[7:0], ack);
    chk_ack(1'b1, ack);
    cnt = int'(a[12:0]);
  endtask

  task automatic wdata(input logic [7:0] d);
    m.wbyte(d, ack);
    chk_ack(1'b1, ack);
    if (!(wp && cnt >= 6144)) mem[cnt] = d;
    cnt = (cnt & 32'h1FE0) | ((cnt + 1) & 32'h1F);
  endtask

  task automatic rdata(input logic mack);
    m.rbyte(mack, b);
    chk_byte(mem[cnt], b);
    cnt = (cnt + 1) % 8192;
  endtask

  // Leaves an acknowledged write device word open for the next command
  task automatic poll();
    int   n;
    logic bsy;
    n = 0;
    repeat (40) begin
      m.start();
      // Busy counts as the start is seen; busy may end while the ignored word is still sent
      bsy = write_busy;
      m.wbyte({DEV_TYPE, cs, 1'b0}, ack);
      chk_ack(~bsy, ack);
      if (ack) break;
      chk_ack(1'b1, bsy);
      n++;
    end
    chk_ack(1'b1, ack);
    chk_ack(1'b1, n > 0);
  endtask

  initial begin
    // About two and a half times the expected run, well under the cycle budget
    #300000;
    fails++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    wp = 1'b0;
    cs = 3'h0;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'hECD9));
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    cs = 3'($urandom);
    repeat (20) @(negedge ref_clk);
    m.start();
    m.wbyte({4'h5, cs, 1'b0}, ack);
    chk_ack(1'b0, ack);
    m.stop();
    // A refused word must also leave the rest of the frame unanswered
    for (int i = 1; i < 8; i++) begin
      m.start();
      m.wbyte({DEV_TYPE, cs ^ 3'(i), 1'b0}, ack);
      chk_ack(1'b0, ack);
      m.wbyte({DEV_TYPE, cs, 1'b0}, ack);
      chk_ack(1'b0, ack);
      m.stop();
    end
    dev(1'b0, 1'b1);
    addr(16'h1FFE);
    repeat (34) wdata(8'($urandom));
    m.stop();
    @(negedge ref_clk) wp = 1'b1;
    poll();
    addr(16'h1FFF);
    wdata(8'h5A);
    m.stop();
    repeat (10) @(negedge ref_clk);
    chk_ack(1'b0, write_busy);
    dev(1'b0, 1'b1);
    addr(16'hE000);
    wdata(8'($urandom));
    m.stop();
    poll();
    addr(16'h1FE0);
    dev(1'b1, 1'b1);
    for (int i = 0; i < 32; i++) rdata(i < 31);
    m.stop();
    dev(1'b1, 1'b1);
    rdata(1'b0);
    m.stop();
    final_report();
  end
endmodule
